// >>> reo_pkg.sv
// Constants and types for the rail force-on override register bank.
// Assumes a register access port from the device's serial slave, one clock.
package reo_pkg;
  localparam logic [7:0] REO_OVERRIDE_OFFSET = 8'hA0;   // Register address
  localparam logic [7:0] REO_OVERRIDE_RESET  = 8'h00;   // Default variant reset
  localparam int         REO_RAILS           = 8;       // Rails per register
  localparam int         REO_BIT_LDO_A2      = 7;       // Field positions
  localparam int         REO_BIT_SWITCH_A1   = 6;
  localparam int         REO_BIT_STEP_6      = 5;
  localparam int         REO_BIT_STEP_5      = 4;
  localparam int         REO_BIT_STEP_4      = 3;
  localparam int         REO_BIT_STEP_3      = 2;
  localparam int         REO_BIT_STEP_2      = 1;
  localparam int         REO_BIT_STEP_1      = 0;

  // One register access from the serial slave
  typedef struct packed {
    logic       write;   // Write strobe, one cycle
    logic       read;    // Read strobe, one cycle
    logic [7:0] addr;    // Register offset
    logic [7:0] wdata;   // Write data
  } reo_req_t;

  // Read answer back to the serial slave
  typedef struct packed {
    logic       valid;   // One-cycle pulse
    logic       hit;     // Address matched this bank
    logic [7:0] rdata;   // Read data, zero on miss
  } reo_rsp_t;
endpackage : reo_pkg

// >>> reo_rail_gate.sv
// Registered per-rail enable gate for a vector of rails.
// Assumes all inputs are synchronous to clock.
`timescale 1ns/100ps
module reo_rail_gate
  import reo_pkg::*;
#(
  parameter int WIDTH = REO_RAILS            // Number of rails gated
)
(
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] kill_n,      // Low turns the rail off
  input  wire logic [WIDTH-1:0] force_on,    // High forces the rail on
  input  wire logic [WIDTH-1:0] seq_enable,  // Pin or power-good sequencing
  output logic      [WIDTH-1:0] rail_enable  // Registered rail enable
);
  // Refuse a gate without rails while elaborating, not at run time
  if (WIDTH < 1)
  begin : g_width_check
    $error("reo_rail_gate: WIDTH must be positive");
  end

  // Kill dominates both override and sequencing; one register stage
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      rail_enable <= '0;
    else
      rail_enable <= kill_n & (force_on | seq_enable);
  end

  // A low kill bit must leave the rail off on the following edge
  kill_wins_a: assert property (@(posedge clock) disable iff (rst)
    (kill_n != '1) |=> ((rail_enable & ~$past(kill_n)) == '0))
    else $error("rail on despite kill bit");
endmodule : reo_rail_gate

// >>> reo_override_bank.sv
// Rail force-on override register and the rail enables it steers.
// Assumes a register port from the serial slave on the same clock, and kill
// and sequencing inputs from logic on the same clock.
`timescale 1ns/100ps
module reo_override_bank
  import reo_pkg::*;
#(
  parameter logic [7:0] RESET_VALUE = REO_OVERRIDE_RESET  // Variant reset
)
(
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire reo_req_t   req,            // Register access request
  output reo_rsp_t        rsp,            // Registered answer
  input  wire logic [7:0] kill_n,         // Per-rail kill bits, low = off
  input  wire logic [7:0] seq_enable,     // Pin or power-good enables
  output logic      [7:0] override_state, // Register contents, for fabric
  output logic      [7:0] rail_enable     // Registered rail enables
);
  logic [7:0] rail_force_on_override_1;   // The override register
  logic       addr_hit;                   // Access addresses this bank

  // Named fields of the override register, one bit per rail; positions
  // come from the package so software and the gate agree on the map
  logic       ldo_rail_a2_force_on;       // Bit 7, LDO rail A2
  logic       load_switch_a1_force_on;    // Bit 6, load switch A1
  logic       step_down_6_force_on;       // Bit 5, step-down rail 6
  logic       step_down_5_force_on;       // Bit 4, step-down rail 5
  logic       step_down_4_force_on;       // Bit 3, step-down rail 4
  logic       step_down_3_force_on;       // Bit 2, step-down rail 3
  logic       step_down_2_force_on;       // Bit 1, step-down rail 2
  logic       step_down_1_force_on;       // Bit 0, step-down rail 1
  // Per-rail kill inputs by name; low turns the rail off whatever is asked
  logic       ldo_rail_a2_kill_n;         // LDO rail A2
  logic       load_switch_a1_kill_n;      // Load switch A1
  logic       step_down_6_kill_n;         // Step-down rail 6
  logic       step_down_5_kill_n;         // Step-down rail 5
  logic       step_down_4_kill_n;         // Step-down rail 4
  logic       step_down_3_kill_n;         // Step-down rail 3
  logic       step_down_2_kill_n;         // Step-down rail 2
  logic       step_down_1_kill_n;         // Step-down rail 1

  // Decode of the single offset
  always_comb
  begin
    if (req.addr == REO_OVERRIDE_OFFSET)
      addr_hit = 1'b1;
    else
      addr_hit = 1'b0;
  end

  // Split the register and the kill vector into per-rail names. Pure
  // wiring: the gate still works on whole vectors, so no extra stage.
  always_comb
  begin
    ldo_rail_a2_force_on    = rail_force_on_override_1[REO_BIT_LDO_A2];
    load_switch_a1_force_on = rail_force_on_override_1[REO_BIT_SWITCH_A1];
    step_down_6_force_on    = rail_force_on_override_1[REO_BIT_STEP_6];
    step_down_5_force_on    = rail_force_on_override_1[REO_BIT_STEP_5];
    step_down_4_force_on    = rail_force_on_override_1[REO_BIT_STEP_4];
    step_down_3_force_on    = rail_force_on_override_1[REO_BIT_STEP_3];
    step_down_2_force_on    = rail_force_on_override_1[REO_BIT_STEP_2];
    step_down_1_force_on    = rail_force_on_override_1[REO_BIT_STEP_1];
    ldo_rail_a2_kill_n      = kill_n[REO_BIT_LDO_A2];
    load_switch_a1_kill_n   = kill_n[REO_BIT_SWITCH_A1];
    step_down_6_kill_n      = kill_n[REO_BIT_STEP_6];
    step_down_5_kill_n      = kill_n[REO_BIT_STEP_5];
    step_down_4_kill_n      = kill_n[REO_BIT_STEP_4];
    step_down_3_kill_n      = kill_n[REO_BIT_STEP_3];
    step_down_2_kill_n      = kill_n[REO_BIT_STEP_2];
    step_down_1_kill_n      = kill_n[REO_BIT_STEP_1];
  end

  // Register write; reset value per variant, all bits read-write
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      rail_force_on_override_1 <= RESET_VALUE;
    else if (req.write && addr_hit)
      rail_force_on_override_1 <= req.wdata;
  end

  // Read answer: one cycle after the strobe, zero data on a miss
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      rsp <= '0;
    else
    begin
      rsp.valid <= req.read;
      rsp.hit   <= req.read && addr_hit;
      rsp.rdata <= (req.read && addr_hit) ? rail_force_on_override_1 : 8'h00;
    end
  end

  // Register mirror so every output leaves a flip-flop
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      override_state <= RESET_VALUE;
    else if (req.write && addr_hit)
      override_state <= req.wdata;
  end

  // Each bit position maps one rail: 7 LDO A2, 6 switch A1, 5..0 step-down
  // 6..1. The gate keeps the kill dominant over force and pins.
  reo_rail_gate #(
    .WIDTH       (REO_RAILS)
  ) u_gate (
    .clock       (clock),
    .rst         (rst),
    .kill_n      (kill_n),
    .force_on    (rail_force_on_override_1),
    .seq_enable  (seq_enable),
    .rail_enable (rail_enable)
  );

  // Written data reaches the register on the next edge
  write_lands_a: assert property (@(posedge clock) disable iff (rst)
    (req.write && req.addr == REO_OVERRIDE_OFFSET) |=>
      rail_force_on_override_1 == $past(req.wdata))
    else $error("override write lost");
  // Readback returns the stored value
  read_back_a: assert property (@(posedge clock) disable iff (rst)
    (req.read && !req.write && req.addr == REO_OVERRIDE_OFFSET) |=>
      (rsp.valid && rsp.rdata == rail_force_on_override_1))
    else $error("override readback wrong");
  // A read of the override offset reports a hit
  read_hit_a: assert property (@(posedge clock) disable iff (rst)
    (req.read && req.addr == REO_OVERRIDE_OFFSET) |=> (rsp.valid && rsp.hit))
    else $error("override read without hit");
  // A read elsewhere still answers, but with no hit and zero data
  miss_read_a: assert property (@(posedge clock) disable iff (rst)
    (req.read && req.addr != REO_OVERRIDE_OFFSET) |=>
      (rsp.valid && !rsp.hit && rsp.rdata == 8'h00))
    else $error("miss read answered wrongly");
  // A write elsewhere must leave the register alone
  miss_write_a: assert property (@(posedge clock) disable iff (rst)
    (req.write && req.addr != REO_OVERRIDE_OFFSET) |=>
      $stable(rail_force_on_override_1))
    else $error("miss write changed override");
  // The answer stands one cycle only: no strobe, no answer
  answer_quiet_a: assert property (@(posedge clock) disable iff (rst)
    !req.read |=> (!rsp.valid && !rsp.hit && rsp.rdata == 8'h00))
    else $error("answer without read strobe");
  // LDO A2 forced on when kill bit high
  ldo_forced_a: assert property (@(posedge clock) disable iff (rst)
    (rail_force_on_override_1[REO_BIT_LDO_A2] && kill_n[REO_BIT_LDO_A2])
      |=> rail_enable[REO_BIT_LDO_A2])
    else $error("LDO A2 not forced on");
  // Load switch A1 forced on
  switch_forced_a: assert property (@(posedge clock) disable iff (rst)
    (rail_force_on_override_1[REO_BIT_SWITCH_A1] && kill_n[REO_BIT_SWITCH_A1])
      |=> rail_enable[REO_BIT_SWITCH_A1])
    else $error("switch A1 not forced on");
  // Step-down 6 forced on
  step6_forced_a: assert property (@(posedge clock) disable iff (rst)
    (rail_force_on_override_1[REO_BIT_STEP_6] && kill_n[REO_BIT_STEP_6])
      |=> rail_enable[REO_BIT_STEP_6])
    else $error("step-down 6 not forced on");
  // Step-down 5 forced on
  step5_forced_a: assert property (@(posedge clock) disable iff (rst)
    (rail_force_on_override_1[REO_BIT_STEP_5] && kill_n[REO_BIT_STEP_5])
      |=> rail_enable[REO_BIT_STEP_5])
    else $error("step-down 5 not forced on");
  // Step-down 4 forced on
  step4_forced_a: assert property (@(posedge clock) disable iff (rst)
    (rail_force_on_override_1[REO_BIT_STEP_4] && kill_n[REO_BIT_STEP_4])
      |=> rail_enable[REO_BIT_STEP_4])
    else $error("step-down 4 not forced on");
  // Step-down 3 forced on
  step3_forced_a: assert property (@(posedge clock) disable iff (rst)
    (rail_force_on_override_1[REO_BIT_STEP_3] && kill_n[REO_BIT_STEP_3])
      |=> rail_enable[REO_BIT_STEP_3])
    else $error("step-down 3 not forced on");
  // Step-down 2 forced on
  step2_forced_a: assert property (@(posedge clock) disable iff (rst)
    (rail_force_on_override_1[REO_BIT_STEP_2] && kill_n[REO_BIT_STEP_2])
      |=> rail_enable[REO_BIT_STEP_2])
    else $error("step-down 2 not forced on");
  // Step-down 1 forced on
  step1_forced_a: assert property (@(posedge clock) disable iff (rst)
    (rail_force_on_override_1[REO_BIT_STEP_1] && kill_n[REO_BIT_STEP_1])
      |=> rail_enable[REO_BIT_STEP_1])
    else $error("step-down 1 not forced on");
  // With its override clear and kill high, each rail tracks sequencing;
  // this is the half of each bit's rule that the forced checks miss
  ldo_follows_a: assert property (@(posedge clock) disable iff (rst)
    (!ldo_rail_a2_force_on && ldo_rail_a2_kill_n)
      |=> rail_enable[REO_BIT_LDO_A2] == $past(seq_enable[REO_BIT_LDO_A2]))
    else $error("LDO A2 not following sequencing");
  // Load switch A1 follows sequencing when not forced
  switch_follows_a: assert property (@(posedge clock) disable iff (rst)
    (!load_switch_a1_force_on && load_switch_a1_kill_n)
      |=> rail_enable[REO_BIT_SWITCH_A1] == $past(seq_enable[REO_BIT_SWITCH_A1]))
    else $error("switch A1 not following sequencing");
  // Step-down 6 follows sequencing when not forced
  step6_follows_a: assert property (@(posedge clock) disable iff (rst)
    (!step_down_6_force_on && step_down_6_kill_n)
      |=> rail_enable[REO_BIT_STEP_6] == $past(seq_enable[REO_BIT_STEP_6]))
    else $error("step-down 6 not following sequencing");
  // Step-down 5 follows sequencing when not forced
  step5_follows_a: assert property (@(posedge clock) disable iff (rst)
    (!step_down_5_force_on && step_down_5_kill_n)
      |=> rail_enable[REO_BIT_STEP_5] == $past(seq_enable[REO_BIT_STEP_5]))
    else $error("step-down 5 not following sequencing");
  // Step-down 4 follows sequencing when not forced
  step4_follows_a: assert property (@(posedge clock) disable iff (rst)
    (!step_down_4_force_on && step_down_4_kill_n)
      |=> rail_enable[REO_BIT_STEP_4] == $past(seq_enable[REO_BIT_STEP_4]))
    else $error("step-down 4 not following sequencing");
  // Step-down 3 follows sequencing when not forced
  step3_follows_a: assert property (@(posedge clock) disable iff (rst)
    (!step_down_3_force_on && step_down_3_kill_n)
      |=> rail_enable[REO_BIT_STEP_3] == $past(seq_enable[REO_BIT_STEP_3]))
    else $error("step-down 3 not following sequencing");
  // Step-down 2 follows sequencing when not forced
  step2_follows_a: assert property (@(posedge clock) disable iff (rst)
    (!step_down_2_force_on && step_down_2_kill_n)
      |=> rail_enable[REO_BIT_STEP_2] == $past(seq_enable[REO_BIT_STEP_2]))
    else $error("step-down 2 not following sequencing");
  // Step-down 1 follows sequencing when not forced
  step1_follows_a: assert property (@(posedge clock) disable iff (rst)
    (!step_down_1_force_on && step_down_1_kill_n)
      |=> rail_enable[REO_BIT_STEP_1] == $past(seq_enable[REO_BIT_STEP_1]))
    else $error("step-down 1 not following sequencing");
  // Each rail is its past kill bit AND (past override bit OR past sequencing)
  seq_follow_a: assert property (@(posedge clock) disable iff (rst)
    1'b1 |=> rail_enable == ($past(kill_n) &
      ($past(rail_force_on_override_1) | $past(seq_enable))))
    else $error("rail enable equation broken");
endmodule : reo_override_bank

// >>> reo_host_model.sv
// Register host model: one-cycle read and write strobes to the bank.
// Assumes a read answer one cycle after the strobe edge.
`timescale 1ns/100ps
module reo_host_model
  import reo_pkg::*;
(
  input  wire logic     clock,
  output reo_req_t      req,
  input  wire reo_rsp_t rsp
);
  initial req = '0;  // Idle bus from time zero
  // Write: strobe for one edge, then release
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    req <= '{write: 1'b1, read: 1'b0, addr: a, wdata: d};
    @(posedge clock);
    req <= '0;
  endtask : wr
  // Read: answer taken once the taking edge has landed
  task automatic rd(input logic [7:0] a, output reo_rsp_t r);
    @(posedge clock);
    req <= '{write: 1'b0, read: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clock);
    req <= '0;
    #1 r = rsp;
  endtask : rd
endmodule : reo_host_model

// >>> reo_override_bank_bench.sv
// Bench for the rail force-on override bank.
// Assumes the host model for register traffic and one 25 MHz clock.
`timescale 1ns/100ps
module reo_override_bank_bench import reo_pkg::*;;
  logic       clock;           // 40 ns period
  logic       rst;             // Async, active high
  logic [7:0] kill_n;          // Low kills a rail
  logic [7:0] seq_enable;      // Pin or power-good enables
  reo_req_t   req;
  reo_rsp_t   rsp;
  logic [7:0] override_state;
  logic [7:0] rail_enable;
  int         error_cnt = 0;
  int         n_tests   = 0;
  reo_override_bank u_reo_override_bank (.clock(clock), .rst(rst), .req(req),
    .rsp(rsp), .kill_n(kill_n), .seq_enable(seq_enable),
    .override_state(override_state), .rail_enable(rail_enable));
  reo_host_model u_reo_host_model (.clock(clock), .req(req), .rsp(rsp));
  task automatic chk(input logic [9:0] g, input logic [9:0] e);
    n_tests++;
    if (g !== e)
    begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  // Read and compare {valid, hit, data}
  task automatic rdchk(input logic [7:0] a, input logic [9:0] e);
    reo_rsp_t r;
    u_reo_host_model.rd(a, r);
    chk({r.valid, r.hit, r.rdata}, e);
  endtask : rdchk
  // Rails lag the register by a cycle, so two edges are waited
  task automatic rails(input logic [7:0] k, input logic [7:0] s, input logic [7:0] e);
    @(posedge clock);
    kill_n <= k;
    seq_enable <= s;
    repeat (2) @(posedge clock);
    #1 chk({2'b00, rail_enable}, {2'b00, e});
  endtask : rails
  task automatic t_reset();
    chk({2'b00, override_state}, {2'b00, REO_OVERRIDE_RESET});
    rdchk(REO_OVERRIDE_OFFSET, {2'b11, REO_OVERRIDE_RESET});
  endtask : t_reset
  // Both data polarities, then a miss that must not disturb the register
  task automatic t_rw();
    u_reo_host_model.wr(REO_OVERRIDE_OFFSET, 8'hA5);
    rdchk(REO_OVERRIDE_OFFSET, 10'h3A5);
    u_reo_host_model.wr(REO_OVERRIDE_OFFSET, 8'h5A);
    u_reo_host_model.wr(8'hA1, 8'hFF);
    rdchk(8'hA1, 10'h200);
    rdchk(REO_OVERRIDE_OFFSET, 10'h35A);
  endtask : t_rw
  // One bit forces only its rail; its kill beats force while others stay on
  task automatic t_bit(input int i);
    logic [7:0] one_hot;
    one_hot = 8'h01 << i;
    u_reo_host_model.wr(REO_OVERRIDE_OFFSET, one_hot);
    rails(8'hFF, 8'h00, one_hot);
    chk({2'b00, override_state}, {2'b00, one_hot});
    rails(~one_hot, 8'hFF, ~one_hot);
  endtask : t_bit
  // Sequencing drives rails while the override is clear, then kill masks a set override
  task automatic t_seq();
    u_reo_host_model.wr(REO_OVERRIDE_OFFSET, 8'h00);
    rails(8'hF3, 8'h3C, 8'h30);
    u_reo_host_model.wr(REO_OVERRIDE_OFFSET, 8'hC3);
    rails(8'h0F, 8'h00, 8'h03);
  endtask : t_seq
  // A reset in mid-run restores the variant value and drops every rail
  task automatic t_rerun();
    u_reo_host_model.wr(REO_OVERRIDE_OFFSET, 8'hFF);
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    #1 chk({2'b00, rail_enable}, 10'h000);
    chk({2'b00, override_state}, {2'b00, REO_OVERRIDE_RESET});
    rdchk(REO_OVERRIDE_OFFSET, {2'b11, REO_OVERRIDE_RESET});
  endtask : t_rerun
  task automatic close_out();
    $display("tests=%0d errors=%0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : close_out
  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  initial
  begin
    rst = 1'b1;
    kill_n = 8'hFF;
    seq_enable = 8'h00;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    #1;
    t_reset();
    t_rw();
    t_bit(REO_BIT_LDO_A2);
    t_bit(REO_BIT_SWITCH_A1);
    t_bit(REO_BIT_STEP_6);
    t_bit(REO_BIT_STEP_5);
    t_bit(REO_BIT_STEP_4);
    t_bit(REO_BIT_STEP_3);
    t_bit(REO_BIT_STEP_2);
    t_bit(REO_BIT_STEP_1);
    t_seq();
    t_rerun();
    close_out();
  end
  // Run needs about 100 cycles; cut off well past that
  initial
  begin
    #100000;
    error_cnt++;
    close_out();
  end
endmodule : reo_override_bank_bench
